// >>> sxr_consts.svh
`ifndef SXR_CONSTS_SVH
`define SXR_CONSTS_SVH

// ==========================================================
// timing
`define SXR_CLK_MHZ     250
`define SXR_HOLD_MS     3000
`define SXR_HOLD_CYC    (`SXR_HOLD_MS * 1000 * `SXR_CLK_MHZ)

// ==========================================================
// save counter
`define SXR_SAVE_LIMIT  16'h03e8
`define SXR_CNT_RST     16'h0000

// ==========================================================
// factory transmission setting
`define SXR_FACT_BAUD   20'h70800
`define SXR_FACT_STOP   2'h2
`define SXR_PAR_EVEN    2'h2

// ==========================================================
// characters
`define SXR_CH_XL       8'h78
`define SXR_CH_XU       8'h58
`define SXR_CH_ZL       8'h7a
`define SXR_CH_ZU       8'h5a
`define SXR_CH_SP       8'h20
`define SXR_CH_CR       8'h0d
`define SXR_CH_COMMA    8'h2c
`define SXR_CH_NL       8'h6e
`define SXR_CH_IL       8'h69
`define SXR_CH_NU       8'h4e
`define SXR_CH_IU       8'h49
`define SXR_CH_YU       8'h59
`define SXR_CH_SL       8'h73

// ==========================================================
// error numbers
`define SXR_E_NONE      3'h0
`define SXR_E001        3'h1
`define SXR_E002        3'h2
`define SXR_E003        3'h3
`define SXR_E004        3'h4
`define SXR_E005        3'h5

`endif

// >>> sxr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sxr_host_model #(
  parameter int TX_CYC = 5,
  parameter int FL_CYC = 8
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic resp_valid_q,
  input  wire logic flash_save_q,
  input  wire logic fail_save,
  output logic      tx_idle,
  output logic      flash_done,
  output logic      flash_ok
);
  // ==========================================================
  // response transmitter
  int   tx_cnt_q;
  int   fl_cnt_q;
  logic ok_q;

  // busy while the response line is shifted out, low the cycle after it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_cnt_q <= 0;
    end else if (resp_valid_q) begin
      tx_cnt_q <= TX_CYC;
    end else if (tx_cnt_q != 0) begin
      tx_cnt_q <= tx_cnt_q - 1;
    end
  end
  assign tx_idle = (tx_cnt_q == 0);

  // ==========================================================
  // flash store
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl_cnt_q <= 0;
    end else if (flash_save_q) begin
      fl_cnt_q <= FL_CYC;
    end else if (fl_cnt_q != 0) begin
      fl_cnt_q <= fl_cnt_q - 1;
    end
  end
  assign flash_done = (fl_cnt_q == 1);

  // status toggles outside the done pulse so a stale read cannot pass
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ok_q <= 1'b0;
    end else begin
      ok_q <= ~ok_q;
    end
  end
  assign flash_ok = flash_done ? ~fail_save : ok_q;
endmodule
`default_nettype wire

// >>> sxr_pkg.sv
`default_nettype none
package sxr_pkg;

  // ==========================================================
  // response messages
  typedef enum logic [3:0] {
    resp_none,
    resp_exit_ask,
    resp_ret_normal,
    resp_ret_init,
    resp_abort,
    resp_z_ask,
    resp_tx_ask,
    resp_tx_show,
    resp_applied,
    resp_saved,
    resp_error
  } sxr_resp_e;

  // ==========================================================
  // interpreter states
  typedef enum logic [4:0] {
    st_idle, st_skip,
    st_x_sp, st_x_tgt, st_x_cr, st_x_ans, st_x_grd, st_x_txw, st_x_hold,
    st_z_arg, st_z_s, st_z_cr, st_z_ans1, st_z_ans2, st_z_apply, st_z_wait, st_z_rep
  } sxr_state_e;

endpackage
`default_nettype wire

// >>> sxr_save_cnt.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxr_consts.svh"
module sxr_save_cnt (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        inc,
  output logic [15:0]      count,
  output logic             over
);

  // ==========================================================
  // counter, saturates so it never wraps back under the limit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= `SXR_CNT_RST;
    end else if (ce && inc && count != 16'hffff) begin
      count <= count + 16'h0001;
    end
  end

  assign over = count > `SXR_SAVE_LIMIT;

endmodule
`default_nettype wire

// >>> sxr_service_cmds.sv
// Functional notes
// - exit is x, space, target, carriage return
// - n/i: dirty config asks, only Y confirms
// - n/i: wait 3 s after response sent
// - i enters init, reloads stored config
// - N goes to normal, no prompt, no hold
// - I goes to init at once, reloads
// - E001 bad entry, E002 count/comma, E003 range
// - other answer gives E003, stays in service
// - answer N reports abort, back to prompt
// - print return message matching target
// - bare z loads factory into live only
// - z s loads factory and saves it
// - confirm restore, second confirm for link change
// - shown factory link is 460800, 2 stop, even
// - after save report saved and count
// - past 1000 saves warn E004, still save
// - failed flash write reports E005
// - z with stray characters reports E002; commas after the space are skipped
`timescale 1ns/10ps
`default_nettype none
`include "sxr_consts.svh"
module sxr_service_cmds
  import sxr_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `SXR_HOLD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        cfg_dirty,
  input  wire logic        tx_params_differ,
  input  wire logic        tx_idle,
  input  wire logic        flash_done,
  input  wire logic        flash_ok,
  output sxr_resp_e        resp_code_q,
  output logic             resp_valid_q,
  output logic [2:0]       resp_err_q,
  output logic [15:0]      save_count,
  output logic [19:0]      fact_baud_q,
  output logic [1:0]       fact_stop_q,
  output logic [1:0]       fact_parity_q,
  output logic             go_normal_q,
  output logic             go_init_q,
  output logic             reload_flash_q,
  output logic             load_factory_q,
  output logic             flash_save_q,
  output logic             busy_q
);

  // ==========================================================
  // declarations
  sxr_state_e  st_q, st_d;
  sxr_resp_e   rsp_code;
  logic        rsp_en;
  logic [2:0]  rsp_err;
  logic [2:0]  err_v;
  logic [7:0]  tgt_q, tgt_d;
  logic        zs_q, zs_d;
  logic        ok_q, ok_d;
  logic        go_n, go_i, reload, factory, save_req, cnt_inc;
  logic [31:0] hold_q;
  logic        hold_done;
  logic        over;
  logic        tgt_ok, tgt_now, is_cr;

  assign is_cr     = rx_char == `SXR_CH_CR;
  assign tgt_now   = tgt_q == `SXR_CH_NU || tgt_q == `SXR_CH_IU;
  assign tgt_ok    = tgt_now || tgt_q == `SXR_CH_NL || tgt_q == `SXR_CH_IL;
  assign hold_done = hold_q == 32'(HOLD_CYC - 1);

  // ==========================================================
  // save counter
  sxr_save_cnt u_cnt (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .inc   (cnt_inc),
    .count (save_count),
    .over  (over)
  );

  // ==========================================================
  // interpreter
  always_comb begin
    st_d     = st_q;
    rsp_en   = 1'b0;
    rsp_code = resp_none;
    rsp_err  = `SXR_E_NONE;
    err_v    = `SXR_E_NONE;
    tgt_d    = tgt_q;
    zs_d     = zs_q;
    ok_d     = ok_q;
    go_n     = 1'b0;
    go_i     = 1'b0;
    reload   = 1'b0;
    factory  = 1'b0;
    save_req = 1'b0;
    cnt_inc  = 1'b0;
    unique case (st_q)
      st_idle: if (rx_valid) begin
        if (rx_char == `SXR_CH_XL || rx_char == `SXR_CH_XU) begin
          st_d = st_x_sp;
        end else if (rx_char == `SXR_CH_ZL || rx_char == `SXR_CH_ZU) begin
          st_d = st_z_arg;
        end else if (!is_cr) begin
          st_d = st_skip;
        end
      end
      st_skip: if (rx_valid && is_cr) begin
        st_d = st_idle;
      end
      st_x_sp: if (rx_valid) begin
        if (rx_char == `SXR_CH_SP) begin
          st_d = st_x_tgt;
        end else if (is_cr || rx_char == `SXR_CH_COMMA) begin
          err_v = `SXR_E002;
        end else begin
          err_v = `SXR_E001;
        end
      end
      st_x_tgt: if (rx_valid) begin
        if (is_cr || rx_char == `SXR_CH_COMMA) begin
          err_v = `SXR_E002;
        end else if (rx_char != `SXR_CH_SP) begin
          tgt_d = rx_char;
          st_d  = st_x_cr;
        end
      end
      st_x_cr: if (rx_valid) begin
        if (!is_cr) begin
          err_v = `SXR_E002;
        end else if (!tgt_ok) begin
          err_v = `SXR_E003;
        end else if (tgt_now) begin
          rsp_en   = 1'b1;
          rsp_code = (tgt_q == `SXR_CH_NU) ? resp_ret_normal : resp_ret_init;
          go_n     = tgt_q == `SXR_CH_NU;
          go_i     = tgt_q == `SXR_CH_IU;
          reload   = tgt_q == `SXR_CH_IU;
          st_d     = st_idle;
        end else if (cfg_dirty) begin
          rsp_en   = 1'b1;
          rsp_code = resp_exit_ask;
          st_d     = st_x_ans;
        end else begin
          rsp_en   = 1'b1;
          rsp_code = (tgt_q == `SXR_CH_NL) ? resp_ret_normal : resp_ret_init;
          st_d     = st_x_grd;
        end
      end
      st_x_ans: if (rx_valid) begin
        rsp_en = 1'b1;
        if (rx_char == `SXR_CH_YU) begin
          rsp_code = (tgt_q == `SXR_CH_NL) ? resp_ret_normal : resp_ret_init;
          st_d     = st_x_grd;
        end else if (rx_char == `SXR_CH_NU) begin
          rsp_code = resp_abort;
          st_d     = st_idle;
        end else begin
          rsp_code = resp_error;
          rsp_err  = `SXR_E003;
          st_d     = st_idle;
        end
      end
      // one guard cycle lets the transmitter see the response first
      st_x_grd: st_d = st_x_txw;
      st_x_txw: if (tx_idle) begin
        st_d = st_x_hold;
      end
      st_x_hold: if (hold_done) begin
        go_n   = tgt_q == `SXR_CH_NL;
        go_i   = tgt_q == `SXR_CH_IL;
        reload = tgt_q == `SXR_CH_IL;
        st_d   = st_idle;
      end
      st_z_arg: if (rx_valid) begin
        if (is_cr) begin
          zs_d     = 1'b0;
          rsp_en   = 1'b1;
          rsp_code = resp_z_ask;
          st_d     = st_z_ans1;
        end else if (rx_char == `SXR_CH_SP) begin
          st_d = st_z_s;
        end else begin
          err_v = `SXR_E002;
        end
      end
      st_z_s: if (rx_valid) begin
        if (rx_char == `SXR_CH_SL) begin
          st_d = st_z_cr;
        end else if (rx_char != `SXR_CH_COMMA) begin
          err_v = `SXR_E002;
        end
      end
      st_z_cr: if (rx_valid) begin
        if (is_cr) begin
          zs_d     = 1'b1;
          rsp_en   = 1'b1;
          rsp_code = resp_z_ask;
          st_d     = st_z_ans1;
        end else begin
          err_v = `SXR_E002;
        end
      end
      st_z_ans1, st_z_ans2: if (rx_valid) begin
        rsp_en = 1'b1;
        if (rx_char == `SXR_CH_YU && st_q == st_z_ans1 && tx_params_differ) begin
          rsp_code = resp_tx_ask;
          st_d     = st_z_ans2;
        end else if (rx_char == `SXR_CH_YU) begin
          rsp_code = (st_q == st_z_ans2) ? resp_tx_show : resp_none;
          rsp_en   = st_q == st_z_ans2;
          st_d     = st_z_apply;
        end else if (rx_char == `SXR_CH_NU) begin
          rsp_code = resp_abort;
          st_d     = st_idle;
        end else begin
          rsp_code = resp_error;
          rsp_err  = `SXR_E003;
          st_d     = st_idle;
        end
      end
      st_z_apply: begin
        factory = 1'b1;
        if (zs_q) begin
          save_req = 1'b1;
          st_d     = st_z_wait;
        end else begin
          rsp_en   = 1'b1;
          rsp_code = resp_applied;
          st_d     = st_idle;
        end
      end
      st_z_wait: if (flash_done) begin
        ok_d    = flash_ok;
        cnt_inc = flash_ok;
        if (over) begin
          rsp_en   = 1'b1;
          rsp_code = resp_error;
          rsp_err  = `SXR_E004;
        end
        st_d = st_z_rep;
      end
      st_z_rep: begin
        rsp_en   = 1'b1;
        rsp_code = ok_q ? resp_saved : resp_error;
        rsp_err  = ok_q ? `SXR_E_NONE : `SXR_E005;
        st_d     = st_idle;
      end
      default: st_d = st_idle;
    endcase
    if (err_v != `SXR_E_NONE) begin
      rsp_en   = 1'b1;
      rsp_code = resp_error;
      rsp_err  = err_v;
      st_d     = is_cr ? st_idle : st_skip;
    end
  end

  // ==========================================================
  // state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q  <= st_idle;
      tgt_q <= 8'h00;
      zs_q  <= 1'b0;
      ok_q  <= 1'b0;
    end else if (ce) begin
      st_q  <= st_d;
      tgt_q <= tgt_d;
      zs_q  <= zs_d;
      ok_q  <= ok_d;
    end
  end

  // ==========================================================
  // hold timer, wide because the figure runs to 3 s of cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_q <= 32'h0000_0000;
    end else if (ce) begin
      hold_q <= (st_q == st_x_hold && !hold_done) ? hold_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ==========================================================
  // response and control outputs; pulses freeze with ce
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_valid_q   <= 1'b0;
      resp_code_q    <= resp_none;
      resp_err_q     <= `SXR_E_NONE;
      go_normal_q    <= 1'b0;
      go_init_q      <= 1'b0;
      reload_flash_q <= 1'b0;
      load_factory_q <= 1'b0;
      flash_save_q   <= 1'b0;
      busy_q         <= 1'b0;
    end else if (ce) begin
      resp_valid_q   <= rsp_en;
      resp_code_q    <= rsp_code;
      resp_err_q     <= rsp_err;
      go_normal_q    <= go_n;
      go_init_q      <= go_i;
      reload_flash_q <= reload;
      load_factory_q <= factory;
      flash_save_q   <= save_req;
      busy_q         <= st_d == st_x_grd || st_d == st_x_txw || st_d == st_x_hold;
    end
  end

  // ==========================================================
  // factory link setting shown with the second prompt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fact_baud_q   <= `SXR_FACT_BAUD;
      fact_stop_q   <= `SXR_FACT_STOP;
      fact_parity_q <= `SXR_PAR_EVEN;
    end else if (ce) begin
      fact_baud_q   <= `SXR_FACT_BAUD;
      fact_stop_q   <= `SXR_FACT_STOP;
      fact_parity_q <= `SXR_PAR_EVEN;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_exit_asked;
    ce && st_q == st_x_ans && rx_valid;
  endsequence

  a_hold_no_go: assert property (
    st_q == st_x_hold && !hold_done |=> !go_normal_q && !go_init_q)
    else $error("mode change during hold");
  a_wait_tx: assert property (
    ce && st_q == st_x_txw && !tx_idle |=> st_q == st_x_txw && busy_q)
    else $error("hold started before response sent");
  a_only_y: assert property (
    (s_exit_asked and (rx_char != `SXR_CH_YU)) |=> st_q == st_idle && !busy_q)
    else $error("exit without Y");
  a_bad_answer: assert property (
    (s_exit_asked and (rx_char != `SXR_CH_YU && rx_char != `SXR_CH_NU))
    |=> resp_valid_q && resp_err_q == `SXR_E003)
    else $error("wrong answer not E003");
  a_answer_n: assert property (
    (s_exit_asked and (rx_char == `SXR_CH_NU))
    |=> resp_code_q == resp_abort && resp_err_q == `SXR_E_NONE)
    else $error("N answer reported error");
  a_now_normal: assert property (
    ce && st_q == st_x_cr && rx_valid && is_cr && tgt_q == `SXR_CH_NU
    |=> go_normal_q && resp_code_q == resp_ret_normal)
    else $error("N not immediate");
  a_now_init: assert property (
    ce && st_q == st_x_cr && rx_valid && is_cr && tgt_q == `SXR_CH_IU
    |=> go_init_q && reload_flash_q)
    else $error("I not immediate");
  a_range_err: assert property (
    ce && st_q == st_x_cr && rx_valid && is_cr && !tgt_ok |=> resp_err_q == `SXR_E003)
    else $error("bad target not E003");
  a_z_save: assert property (
    ce && st_q == st_z_apply && zs_q |=> load_factory_q && flash_save_q)
    else $error("z s did not save");
  a_z_live: assert property (
    ce && st_q == st_z_apply && !zs_q |=> load_factory_q && !flash_save_q)
    else $error("bare z saved");
  a_save_warn: assert property (
    ce && st_q == st_z_wait && flash_done && over |=> resp_err_q == `SXR_E004)
    else $error("no E004 warning");
  a_save_fail: assert property (
    ce && st_q == st_z_rep && !ok_q |=> resp_err_q == `SXR_E005)
    else $error("no E005");

endmodule
`default_nettype wire

// >>> sxr_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxr_consts.svh"
module testbench;
  import sxr_pkg::*;
  localparam int HOLD = 20;
  localparam int TXC  = 5;
  logic        mclk, rst, ce, rx_valid, cfg_dirty, tx_params_differ, fail_save;
  logic [7:0]  rx_char;
  logic        tx_idle, flash_done, flash_ok, resp_valid_q, busy_q;
  logic        go_normal_q, go_init_q, reload_flash_q, load_factory_q, flash_save_q;
  sxr_resp_e   resp_code_q;
  logic [2:0]  resp_err_q;
  logic [15:0] save_count;
  logic [19:0] fact_baud_q;
  logic [1:0]  fact_stop_q, fact_parity_q;
  logic [6:0]  evs;
  int          n_fail, n_compared, cyc, t_resp;
  int          ev[7];
  int          t_ev[7];
  sxr_resp_e   codes[$];
  logic [2:0]  errs[$];

  sxr_service_cmds #(.HOLD_CYC(HOLD)) sxr_service_cmds_inst (.mclk(mclk), .rst(rst),
    .ce(ce), .rx_valid(rx_valid), .rx_char(rx_char), .cfg_dirty(cfg_dirty),
    .tx_params_differ(tx_params_differ), .tx_idle(tx_idle), .flash_done(flash_done),
    .flash_ok(flash_ok), .resp_code_q(resp_code_q), .resp_valid_q(resp_valid_q),
    .resp_err_q(resp_err_q), .save_count(save_count), .fact_baud_q(fact_baud_q),
    .fact_stop_q(fact_stop_q), .fact_parity_q(fact_parity_q), .go_normal_q(go_normal_q),
    .go_init_q(go_init_q), .reload_flash_q(reload_flash_q),
    .load_factory_q(load_factory_q), .flash_save_q(flash_save_q), .busy_q(busy_q));
  sxr_host_model #(.TX_CYC(TXC), .FL_CYC(8)) sxr_host_model_inst (.mclk(mclk), .rst(rst),
    .resp_valid_q(resp_valid_q), .flash_save_q(flash_save_q), .fail_save(fail_save),
    .tx_idle(tx_idle), .flash_done(flash_done), .flash_ok(flash_ok));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // monitor: registered outputs read before this edge updates them
  always @(posedge mclk) begin
    cyc++;
    evs = {resp_valid_q && (resp_code_q == resp_saved || resp_err_q == `SXR_E005),
           resp_valid_q && resp_err_q == `SXR_E004, flash_save_q, load_factory_q,
           reload_flash_q, go_init_q, go_normal_q};
    if (resp_valid_q) begin
      codes.push_back(resp_code_q);
      errs.push_back(resp_err_q);
      t_resp = cyc;
    end
    for (int k = 0; k < 7; k++) begin
      if (evs[k] === 1'b1) begin
        ev[k]++;
        t_ev[k] = cyc;
      end
    end
  end

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_val(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // compares the newest response since the last check, then forgets them all
  task automatic chk_last(sxr_resp_e c, logic [2:0] e);
    sxr_resp_e  gc;
    logic [2:0] ge;
    gc = (codes.size() > 0) ? codes[$] : resp_none;
    ge = (errs.size() > 0) ? errs[$] : 3'h7;
    n_compared++;
    if (gc !== c || ge !== e) begin
      n_fail++;
      $display("CHECK FAILED resp expected %s/%0d seen %s/%0d", c.name(), e, gc.name(), ge);
    end
    codes.delete();
    errs.delete();
  endtask

  task automatic send(logic [7:0] c);
    @(negedge mclk);
    rx_valid = 1'b1;
    rx_char  = c;
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask

  task automatic send_cmd(string s);
    for (int i = 0; i < s.len(); i++) send(s[i]);
    send(`SXR_CH_CR);
    repeat (3) @(negedge mclk);
  endtask

  task automatic answer(logic [7:0] c);
    send(c);
    repeat (3) @(negedge mclk);
  endtask

  task automatic wait_ev(int k, int exp, int lim);
    for (int i = 0; i < lim && ev[k] < exp; i++) @(negedge mclk);
    if (ev[k] < exp) begin
      n_fail++;
      $display("CHECK FAILED wait event %0d expected %0d seen %0d", k, exp, ev[k]);
      finish_test();
    end
  endtask

  task automatic do_save();
    int b;
    b = ev[6];
    send_cmd("z s");
    answer(`SXR_CH_YU);
    if (tx_params_differ) answer(`SXR_CH_YU);
    wait_ev(6, b + 1, 200);
    repeat (2) @(negedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_exit_hold();
    int b;
    b = ev[0];
    cfg_dirty = 1'b0;
    send_cmd("x n");
    chk_last(resp_ret_normal, `SXR_E_NONE);
    chk_val("busy", 1, busy_q);
    send_cmd("x N");
    chk_last(resp_none, 3'h7);
    chk_val("early go", b, ev[0]);
    wait_ev(0, b + 1, HOLD + TXC + 60);
    chk_val("hold", 1, (t_ev[0] - t_resp) >= HOLD + TXC);
    repeat (4) @(negedge mclk);
    chk_val("one go", b + 1, ev[0]);
    $display("test exit_hold done");
  endtask

  task automatic t_exit_init();
    int b;
    b = ev[1];
    cfg_dirty = 1'b1;
    send_cmd("x i");
    chk_last(resp_exit_ask, `SXR_E_NONE);
    answer(`SXR_CH_YU);
    chk_last(resp_ret_init, `SXR_E_NONE);
    wait_ev(1, b + 1, HOLD + TXC + 60);
    chk_val("reload", t_ev[1], t_ev[2]);
    chk_val("init", 1, (t_ev[1] - t_resp) >= HOLD + TXC);
    $display("test exit_init done");
  endtask

  task automatic t_exit_answers();
    int g;
    g = ev[0] + ev[1];
    cfg_dirty = 1'b1;
    send_cmd("x n");
    answer(`SXR_CH_NU);
    chk_last(resp_abort, `SXR_E_NONE);
    send_cmd("x n");
    answer(`SXR_CH_NL);
    chk_last(resp_error, `SXR_E003);
    send_cmd("x i");
    answer(8'h79);
    chk_last(resp_error, `SXR_E003);
    repeat (HOLD + TXC + 10) @(negedge mclk);
    chk_val("stay", g, ev[0] + ev[1]);
    $display("test exit_answers done");
  endtask

  task automatic t_exit_now();
    int r;
    r = ev[2];
    cfg_dirty = 1'b1;
    send_cmd("x N");
    chk_last(resp_ret_normal, `SXR_E_NONE);
    chk_val("now normal", t_resp, t_ev[0]);
    send_cmd("x I");
    chk_last(resp_ret_init, `SXR_E_NONE);
    chk_val("now init", t_resp, t_ev[1]);
    chk_val("now reload", r + 1, ev[2]);
    $display("test exit_now done");
  endtask

  task automatic t_exit_errs();
    string      cmd[5] = '{"xq", "x,", "x q", "x nn", "x"};
    logic [2:0] exp[5] = '{`SXR_E001, `SXR_E002, `SXR_E003, `SXR_E002, `SXR_E002};
    for (int i = 0; i < 5; i++) begin
      send_cmd(cmd[i]);
      chk_last(resp_error, exp[i]);
    end
    $display("test exit_errs done");
  endtask

  // enable low must drop characters and hold the go_normal_q pulse
  task automatic t_clock_enable();
    int g;
    g = ev[0];
    ce = 1'b0;
    send_cmd("x N");
    chk_last(resp_none, 3'h7);
    chk_val("frozen go", g, ev[0]);
    ce = 1'b1;
    send(`SXR_CH_XL);
    send(`SXR_CH_SP);
    send(`SXR_CH_NU);
    send(`SXR_CH_CR);
    ce = 1'b0;
    repeat (2) @(negedge mclk);
    chk_val("held go", 1, go_normal_q);
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    chk_val("go ends", 0, go_normal_q);
    chk_last(resp_ret_normal, `SXR_E_NONE);
    $display("test clock_enable done");
  endtask

  task automatic t_restore_bare();
    int f, s;
    f = ev[3];
    s = ev[4];
    tx_params_differ = 1'b0;
    send_cmd("z");
    chk_last(resp_z_ask, `SXR_E_NONE);
    answer(`SXR_CH_YU);
    chk_last(resp_applied, `SXR_E_NONE);
    chk_val("load", f + 1, ev[3]);
    chk_val("no store", s, ev[4]);
    send_cmd("z");
    answer(`SXR_CH_NU);
    chk_last(resp_abort, `SXR_E_NONE);
    send_cmd("zq");
    chk_last(resp_error, `SXR_E002);
    send_cmd("z t");
    chk_last(resp_error, `SXR_E002);
    $display("test restore_bare done");
  endtask

  task automatic t_restore_save();
    logic [15:0] c;
    c = save_count;
    tx_params_differ = 1'b1;
    send_cmd("z s");
    chk_last(resp_z_ask, `SXR_E_NONE);
    answer(`SXR_CH_YU);
    chk_last(resp_tx_ask, `SXR_E_NONE);
    answer(`SXR_CH_YU);
    chk_last(resp_tx_show, `SXR_E_NONE);
    chk_val("baud", 460800, fact_baud_q);
    chk_val("stop", 2, fact_stop_q);
    chk_val("parity", 2, fact_parity_q);
    wait_ev(6, ev[6] + 1, 200);
    chk_last(resp_saved, `SXR_E_NONE);
    chk_val("count", c + 1, save_count);
    tx_params_differ = 1'b0;
    fail_save = 1'b1;
    do_save();
    chk_last(resp_error, `SXR_E005);
    chk_val("count kept", c + 1, save_count);
    fail_save = 1'b0;
    $display("test restore_save done");
  endtask

  task automatic t_save_limit();
    int w;
    for (int i = 0; i < 1100 && save_count < 16'h03e8; i++) do_save();
    w = ev[5];
    do_save();
    chk_val("no warn", w, ev[5]);
    do_save();
    chk_val("warn", w + 1, ev[5]);
    chk_last(resp_saved, `SXR_E_NONE);
    chk_val("count", 1002, save_count);
    $display("test save_limit done");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    rx_valid = 1'b0;
    rx_char = 8'h00;
    cfg_dirty = 1'b0;
    tx_params_differ = 1'b0;
    fail_save = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    chk_val("rst count", 0, save_count);
    chk_val("rst busy", 0, busy_q);
    t_exit_hold();
    t_exit_init();
    t_exit_answers();
    t_exit_now();
    t_exit_errs();
    t_clock_enable();
    t_restore_bare();
    t_restore_save();
    t_save_limit();
    finish_test();
  end
endmodule
`default_nettype wire
